/* common/insn_decode_pkg.sv */
// Package for the instruction decode and trap vector block.
// Assumes a single processor clock domain; no software-visible registers.
package insn_decode_pkg;

    // Immediate selector codes
    localparam logic [4:0] SEL_LAST_SMALL = 5'h10;
    localparam logic [4:0] SEL_IMM32      = 5'h11;
    localparam logic [4:0] SEL_ZEXT16     = 5'h12;
    localparam logic [4:0] SEL_OEXT16     = 5'h13;
    localparam logic [4:0] SEL_BIT5       = 5'h14;
    localparam logic [4:0] SEL_BIT6       = 5'h15;
    localparam logic [4:0] SEL_BIT7       = 5'h16;
    localparam logic [4:0] SEL_BIT31      = 5'h17;
    localparam logic [4:0] SEL_NEG_FIRST  = 5'h18;
    localparam logic [4:0] SEL_ALL        = 5'h1f;
    localparam logic [4:0] NEG_BIAS       = 5'h10;

    // Immediate selector field positions
    localparam int SEL_HI_BIT = 8;
    localparam int SEL_LO_MSB = 3;

    // Opcode bytes (row, column) and rows of immediate, shift, float, branch, extend and trap groups
    localparam logic [7:0] OP_ADD_IMM_LO    = 8'h68;
    localparam logic [7:0] OP_ADD_S_IMM_LO  = 8'h6c;
    localparam logic [7:0] OP_CMP_BITS_LO   = 8'h70;
    localparam logic [7:0] OP_AND_NOT_LO    = 8'h74;
    localparam logic [3:0] ROW_IMM_A        = 4'h6;
    localparam logic [3:0] ROW_IMM_B        = 4'h7;
    localparam logic [3:0] ROW_SHIFT        = 4'h8;
    localparam logic [3:0] ROW_SHIFT_I      = 4'ha;
    localparam logic [3:0] ROW_FLOAT        = 4'hc;
    localparam logic [3:0] ROW_BRANCH       = 4'hf;
    localparam logic [7:0] OP_EXTEND        = 8'hce;
    localparam logic [7:0] OP_TRAP_LO       = 8'hfc;

    // Extended DSP operation codes
    localparam int EXT_COUNT = 13;
    localparam logic [15:0] EXT_CODES [EXT_COUNT] = '{
        16'h0100, 16'h0104, 16'h0106, 16'h010a, 16'h010e, 16'h011a, 16'h011e,
        16'h002a, 16'h002e, 16'h0046, 16'h004e, 16'h0086, 16'h0096};

    // Vector table at top of memory
    localparam logic [31:0] VEC_BASE       = 32'hffff_ff00;
    localparam logic [5:0]  VEC_ALL_ONES   = 6'd63;
    localparam logic [5:0]  VEC_RESET      = 6'd62;
    localparam logic [5:0]  VEC_RANGE      = 6'd60;
    localparam logic [5:0]  VEC_XOVF       = 6'd59;
    localparam logic [5:0]  VEC_PARITY     = 6'd58;
    localparam logic [5:0]  VEC_TRACE      = 6'd57;
    localparam logic [5:0]  VEC_TIMER      = 6'd55;
    localparam logic [5:0]  VEC_IO3        = 6'd54;
    localparam logic [5:0]  VEC_EXT_IRQ_ONE       = 6'd53;
    localparam logic [5:0]  VEC_EXT_IRQ_TWO       = 6'd52;
    localparam logic [5:0]  VEC_EXT_IRQ_THREE       = 6'd51;
    localparam logic [5:0]  VEC_EXT_IRQ_FOUR       = 6'd50;
    localparam logic [5:0]  VEC_IO1        = 6'd49;
    localparam logic [5:0]  VEC_IO2        = 6'd48;

    // Priorities, 0 highest
    localparam logic [4:0] PRI_RESET  = 5'd0;
    localparam logic [4:0] PRI_RANGE  = 5'd2;
    localparam logic [4:0] PRI_XOVF   = 5'd3;
    localparam logic [4:0] PRI_PARITY = 5'd4;
    localparam logic [4:0] PRI_IO3    = 5'd5;
    localparam logic [4:0] PRI_TIMER0 = 5'd6;
    localparam logic [4:0] PRI_EXT_IRQ_ONE   = 5'd7;
    localparam logic [4:0] PRI_EXT_IRQ_TWO   = 5'd9;
    localparam logic [4:0] PRI_EXT_IRQ_THREE   = 5'd11;
    localparam logic [4:0] PRI_EXT_IRQ_FOUR   = 5'd13;
    localparam logic [4:0] PRI_IO1    = 5'd14;
    localparam logic [4:0] PRI_IO2    = 5'd15;
    localparam logic [4:0] PRI_TRACE  = 5'd16;
    localparam logic [4:0] PRI_NONE   = 5'd31;

    typedef enum logic [1:0] {
        CLS_NORMAL,
        CLS_EXTEND,
        CLS_UNDEFINED
    } insn_class_t;

    // Instruction handed from fetch
    typedef struct packed {
        logic        valid;
        logic [15:0] opcode;
        logic [15:0] half1;
        logic [15:0] half2;
    } fetch_word_t;

    // Pending exception and interrupt events
    typedef struct packed {
        logic reset_req;
        logic range_err;
        logic ext_overflow;
        logic parity_err;
        logic trace;
        logic timer_irq;
        logic io_pin_irq_three;
        logic ext_irq_one;
        logic ext_irq_two;
        logic ext_irq_three;
        logic ext_irq_four;
        logic io_pin_irq_one;
        logic io_pin_irq_two;
    } event_req_t;

    // Decoded result towards execute
    typedef struct packed {
        logic        valid;
        insn_class_t cls;
        logic [3:0]  row;
        logic [3:0]  col;
        logic [4:0]  imm_sel;
        logic [31:0] imm_value;
        logic        any_byte_zero_test;
        logic        carry_conditioned_add;
        logic        ext_valid;
        logic [15:0] ext_code;
        logic [3:0]  ext_index;
        logic        sw_trap;
        logic        all_ones_trap;
        logic [31:0] trap_addr;
    } decode_out_t;

    // Selected exception vector
    typedef struct packed {
        logic        valid;
        logic [5:0]  entry;
        logic [4:0]  priority_level;
        logic [31:0] addr;
    } vector_out_t;

endpackage

/* src/insn_decode_trap_vectors.sv */
// Decode stage: immediates, opcode class, DSP extension codes, trap vectors.
// Assumes fetch delivers instruction halfwords synchronously on core_clk.
// Summary of operation
// - selector is bit 8 then bits 3..0
// - selectors 0..16 yield themselves, compare exception
// - add immediates: selector 0 means carry add
// - 17,18,19 take following halfwords, extended
// - 20,21,22 give 32, 64, 128
// - 23 gives only bit 31 set
// - 31 at compare/and-not: bit 31 clear
// - 31 elsewhere gives all ones
// - class from row 15..12, column 11..8
// - extend prefix takes next halfword as code
// - exactly thirteen extension codes recognised
// - vector entries spaced four bytes
// - conditional traps share unconditional trap entries
// - table at top memory, last 256 bytes from base ffffff00
// - all-ones code traps through entry 63
// - exception entries and fixed priorities
// - interrupt entries, selectable timer priority
module insn_decode_trap_vectors
    import insn_decode_pkg::*;
(
    input  wire logic                      core_clk,   // Processor clock
    input  wire logic                      sys_rst,    // Synchronous reset, high
    input  wire insn_decode_pkg::fetch_word_t fetch_in, // Instruction from fetch
    input  wire insn_decode_pkg::event_req_t  events_in, // Pending event levels
    input  wire logic [1:0]                timer_pri_sel, // Timer priority 6/8/10/12
    output insn_decode_pkg::decode_out_t   dec_out,    // Decoded instruction
    output insn_decode_pkg::vector_out_t   vec_out     // Winning exception vector
);
    import insn_decode_pkg::*;

    decode_out_t dec_reg;
    decode_out_t dec_next;
    vector_out_t vec_reg;
    vector_out_t vec_next;

    logic [3:0]  row;
    logic [3:0]  col;
    logic [7:0]  op_hi;
    logic [4:0]  sel;
    logic        uses_imm;
    logic        is_cmp_bits;
    logic        is_and_not;
    logic        is_add_imm;
    logic [31:0] imm_val;
    logic        ext_hit;
    logic [3:0]  ext_idx;
    logic [4:0]  timer_pri;

    assign op_hi = fetch_in.opcode[15:8];
    assign row   = fetch_in.opcode[15:12];
    assign col   = fetch_in.opcode[11:8];
    assign sel   = {fetch_in.opcode[SEL_HI_BIT], fetch_in.opcode[SEL_LO_MSB:0]};

    assign is_cmp_bits = {op_hi[7:2], 2'b00} == OP_CMP_BITS_LO;
    assign is_and_not  = {op_hi[7:2], 2'b00} == OP_AND_NOT_LO;
    assign is_add_imm  = ({op_hi[7:2], 2'b00} == OP_ADD_IMM_LO) ||
                         ({op_hi[7:2], 2'b00} == OP_ADD_S_IMM_LO);
    // Whole of rows 6 and 7 is register-immediate, compare and and-not included
    assign uses_imm    = (row == ROW_IMM_A || row == ROW_IMM_B);

    // Immediate expansion
    always_comb begin
        imm_val = 32'h0000_0000;
        if (sel <= SEL_LAST_SMALL) begin
            imm_val = {27'h0, sel};
        end else begin
            case (sel)
                SEL_IMM32:  imm_val = {fetch_in.half1, fetch_in.half2};
                SEL_ZEXT16: imm_val = {16'h0000, fetch_in.half1};
                SEL_OEXT16: imm_val = {16'hffff, fetch_in.half1};
                SEL_BIT5:   imm_val = 32'h0000_0020;
                SEL_BIT6:   imm_val = 32'h0000_0040;
                SEL_BIT7:   imm_val = 32'h0000_0080;
                SEL_BIT31:  imm_val = 32'h8000_0000;
                SEL_ALL: begin
                    if (is_cmp_bits || is_and_not) begin
                        imm_val = 32'h7fff_ffff;
                    end else begin
                        imm_val = 32'hffff_ffff;
                    end
                end
                default: begin
                    // Low five bits of -8..-2 equal the selector 24..30 itself
                    imm_val = {{27{1'b1}}, sel};
                end
            endcase
        end
    end

    // Extension code lookup
    always_comb begin
        ext_hit = 1'b0;
        ext_idx = 4'h0;
        for (int i = 0; i < EXT_COUNT; i++) begin
            if (fetch_in.half1 == EXT_CODES[i]) begin
                ext_hit = 1'b1;
                ext_idx = 4'(i);
            end
        end
    end

    // Decode result
    always_comb begin
        dec_next       = '0;
        dec_next.valid = fetch_in.valid;
        dec_next.row   = row;
        dec_next.col   = col;
        dec_next.cls   = CLS_NORMAL;
        if ((row == ROW_SHIFT && (col == 4'hc || col == 4'hd)) ||
            (row == ROW_SHIFT_I && col[3:2] == 2'b11)) begin
            dec_next.cls = CLS_UNDEFINED;
        end
        if (uses_imm) begin
            dec_next.imm_sel   = sel;
            dec_next.imm_value = imm_val;
            if (sel == 5'h00 && is_cmp_bits) begin
                dec_next.any_byte_zero_test = 1'b1;
                dec_next.imm_value          = 32'h0000_0000;
            end
            if (sel == 5'h00 && is_add_imm) begin
                dec_next.carry_conditioned_add = 1'b1;
                dec_next.imm_value             = 32'h0000_0000;
            end
        end
        if (op_hi == OP_EXTEND) begin
            dec_next.cls       = ext_hit ? CLS_EXTEND : CLS_UNDEFINED;
            dec_next.ext_code  = fetch_in.half1;
            dec_next.ext_valid = ext_hit;
            dec_next.ext_index = ext_idx;
        end
        // Trap number is bits 9..8 and 3..0 for conditional and plain traps alike
        if ({op_hi[7:2], 2'b00} == OP_TRAP_LO && op_hi != OP_TRAP_LO) begin
            dec_next.sw_trap   = 1'b1;
            dec_next.trap_addr = VEC_BASE + {24'h0, op_hi[1:0], fetch_in.opcode[3:0], 2'b00};
        end
        if (fetch_in.opcode == 16'hffff) begin
            dec_next.all_ones_trap = 1'b1;
            dec_next.sw_trap       = 1'b0;
            dec_next.cls           = CLS_UNDEFINED;
            dec_next.trap_addr     = VEC_BASE + {24'h0, VEC_ALL_ONES, 2'b00};
        end
    end

    always_comb begin
        case (timer_pri_sel)
            2'd0:    timer_pri = PRI_TIMER0;
            2'd1:    timer_pri = PRI_TIMER0 + 5'd2;
            2'd2:    timer_pri = PRI_TIMER0 + 5'd4;
            default: timer_pri = PRI_TIMER0 + 5'd6;
        endcase
    end

    // Priority selection: lowest level number wins
    always_comb begin
        logic [5:0] ent;
        logic [4:0] pri;
        ent = 6'h00;
        pri = PRI_NONE;
        if (events_in.io_pin_irq_two    && PRI_IO2  < pri) begin ent = VEC_IO2;  pri = PRI_IO2;  end
        if (events_in.io_pin_irq_one    && PRI_IO1  < pri) begin ent = VEC_IO1;  pri = PRI_IO1;  end
        if (events_in.ext_irq_four      && PRI_EXT_IRQ_FOUR < pri) begin ent = VEC_EXT_IRQ_FOUR; pri = PRI_EXT_IRQ_FOUR; end
        if (events_in.ext_irq_three     && PRI_EXT_IRQ_THREE < pri) begin ent = VEC_EXT_IRQ_THREE; pri = PRI_EXT_IRQ_THREE; end
        if (events_in.ext_irq_two       && PRI_EXT_IRQ_TWO < pri) begin ent = VEC_EXT_IRQ_TWO; pri = PRI_EXT_IRQ_TWO; end
        if (events_in.ext_irq_one       && PRI_EXT_IRQ_ONE < pri) begin ent = VEC_EXT_IRQ_ONE; pri = PRI_EXT_IRQ_ONE; end
        if (events_in.timer_irq         && timer_pri < pri) begin ent = VEC_TIMER; pri = timer_pri; end
        if (events_in.io_pin_irq_three  && PRI_IO3  < pri) begin ent = VEC_IO3;  pri = PRI_IO3;  end
        if (events_in.trace             && PRI_TRACE < pri) begin ent = VEC_TRACE; pri = PRI_TRACE; end
        if (events_in.parity_err        && PRI_PARITY < pri) begin ent = VEC_PARITY; pri = PRI_PARITY; end
        if (events_in.ext_overflow      && PRI_XOVF < pri) begin ent = VEC_XOVF; pri = PRI_XOVF; end
        if (events_in.range_err         && PRI_RANGE < pri) begin ent = VEC_RANGE; pri = PRI_RANGE; end
        if (events_in.reset_req) begin
            ent = VEC_RESET;
            pri = PRI_RESET;
        end
        vec_next.valid          = (pri != PRI_NONE);
        vec_next.entry          = ent;
        vec_next.priority_level = pri;
        vec_next.addr           = VEC_BASE + {24'h0, ent, 2'b00};
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dec_reg <= '0;
        end else begin
            dec_reg <= dec_next;
        end
    end

    // Vector output restarts at the reset entry, as the table sits at top memory after reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vec_reg <= '{valid: 1'b1, entry: VEC_RESET, priority_level: PRI_RESET,
                         addr: VEC_BASE + {24'h0, VEC_RESET, 2'b00}};
        end else begin
            vec_reg <= vec_next;
        end
    end

    assign dec_out = dec_reg;
    assign vec_out = vec_reg;

endmodule

/* verification/fetch_stage_model.sv */
// Fetch stage model: presents one instruction word per clock edge.
// Assumes the bench loads next_word before each rising edge.
module fetch_stage_model
    import insn_decode_pkg::*;
(
    input  wire logic                         core_clk,  // Clock
    input  wire insn_decode_pkg::fetch_word_t next_word, // Word to present
    output insn_decode_pkg::fetch_word_t      fetch_in   // Toward decode
);
    timeunit 1ns;
    timeprecision 1ps;
    initial fetch_in = '0;
    // Idle halves toggle so stale data never passes for a word
    always @(posedge core_clk) begin
        #1;
        if (next_word.valid)
            fetch_in = next_word;
        else
            fetch_in = '{1'b0, ~fetch_in.opcode, ~fetch_in.half1, ~fetch_in.half2};
    end
endmodule

/* verification/insn_decode_asserts.sv */
// Checker for the decode and vector block, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
module insn_decode_asserts
    import insn_decode_pkg::*;
(
    input wire logic                        core_clk,      // Clock
    input wire logic                        sys_rst,       // Reset
    input wire insn_decode_pkg::fetch_word_t fetch_in,     // From fetch
    input wire insn_decode_pkg::event_req_t  events_in,    // Events
    input wire logic [1:0]                  timer_pri_sel, // Timer priority
    input wire insn_decode_pkg::decode_out_t dec_out,      // Decode result
    input wire insn_decode_pkg::vector_out_t vec_out       // Vector result
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic rimm;
    logic trap;
    assign rimm = fetch_in.valid && fetch_in.opcode[15:13] == 3'b011;
    assign trap = fetch_in.valid && fetch_in.opcode[15:8] >= 8'hfd;

    valid_follow_a: assert property (fetch_in.valid |=> dec_out.valid)
        else $error("decode valid not passed on");
    sel_concat_a: assert property (rimm |=> dec_out.imm_sel == {$past(fetch_in.opcode[8]), $past(fetch_in.opcode[3:0])})
        else $error("selector not formed from bit 8 and low nibble");
    bit31_only_a: assert property (rimm && fetch_in.opcode[8] && fetch_in.opcode[3:0] == 4'h7 |=> dec_out.imm_value == 32'h8000_0000)
        else $error("selector 23 constant wrong");
    ext_code_a: assert property (fetch_in.valid && fetch_in.opcode[15:8] == 8'hce |=> dec_out.ext_code == $past(fetch_in.half1))
        else $error("extension code not taken from next halfword");
    all_ones_a: assert property (fetch_in.valid && &fetch_in.opcode |=> dec_out.all_ones_trap && dec_out.trap_addr == 32'hffff_fffc)
        else $error("all ones code did not trap to last entry");
    trap_share_a: assert property (trap |=> dec_out.trap_addr == {24'hffffff, $past(fetch_in.opcode[9:8]), $past(fetch_in.opcode[3:0]), 2'b00})
        else $error("trap address wrong for trap number");
    vec_spacing_a: assert property (vec_out.valid |-> vec_out.addr == {24'hffffff, vec_out.entry, 2'b00})
        else $error("vector address not base plus four per entry");
    reset_wins_a: assert property (events_in.reset_req |=> vec_out.entry == 6'd62 && vec_out.priority_level == 5'd0)
        else $error("reset request did not win");
    timer_pri_a: assert property (events_in == 13'h080 |=> vec_out.entry == 6'd55 && vec_out.priority_level == 5'd6 + {$past(timer_pri_sel), 1'b0})
        else $error("timer entry or priority wrong");
endmodule

bind insn_decode_trap_vectors insn_decode_asserts insn_decode_asserts_i (.core_clk, .sys_rst, .fetch_in, .events_in,
    .timer_pri_sel, .dec_out, .vec_out);

/* verification/insn_decode_trap_vectors_test.sv */
// Bench for the decode block: immediates, classes, traps and event vectors.
// Assumes the fetch model presents each word one edge before decode samples it.
module insn_decode_trap_vectors_test;
    timeunit 1ns;
    timeprecision 1ps;
    import insn_decode_pkg::*;
    logic        core_clk = 0;
    logic        sys_rst = 1;
    logic [1:0]  tsel = '0;
    event_req_t  ev = '0;
    fetch_word_t next_word = '0;
    fetch_word_t fetch_in;
    decode_out_t dec_out;
    vector_out_t vec_out;
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [7:0]  bases [5] = '{8'h68, 8'h6c, 8'h7c, 8'h70, 8'h74};
    logic [7:0]  bad [6] = '{8'hce, 8'h8c, 8'h8d, 8'hac, 8'had, 8'haf};
    int          ents [13] = '{48, 49, 50, 51, 52, 53, 54, 55, 57, 58, 59, 60, 62};
    int          pris [13] = '{15, 14, 13, 11, 9, 7, 5, 0, 16, 4, 3, 2, 0};

    fetch_stage_model fetch_stage_model_i (.core_clk, .next_word, .fetch_in);
    insn_decode_trap_vectors insn_decode_trap_vectors_i (.core_clk, .sys_rst, .fetch_in, .events_in(ev),
        .timer_pri_sel(tsel), .dec_out, .vec_out);

    always #2.5 core_clk = ~core_clk;

    // Whole run needs under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end

    function automatic logic [31:0] exp_imm(logic [15:0] op, logic [15:0] h1, logic [15:0] h2);
        logic [4:0] s;
        s = {op[8], op[3:0]};
        if (s <= 5'd16)
            return {27'h0, s};
        case (s)
            5'd17: return {h1, h2};
            5'd18: return {16'h0, h1};
            5'd19: return {16'hffff, h1};
            5'd20, 5'd21, 5'd22: return 32'h1 << (s - 5'd15);
            5'd23: return 32'h8000_0000;
            5'd31: return op[15:11] == 5'b01110 ? 32'h7fff_ffff : 32'hffff_ffff;
            default: return {27'h7ffffff, s};
        endcase
    endfunction

    function automatic logic [10:0] exp_vec(event_req_t e, logic [1:0] t);
        int b;
        int p;
        int q;
        b = 0;
        p = 99;
        for (int i = 0; i < 13; i++) begin
            q = (i == 7) ? 6 + 2 * t : pris[i];
            if (e[i] && q < p) begin
                b = i;
                p = q;
            end
        end
        return {6'(ents[b]), 5'(p)};
    endfunction

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task go(input logic [15:0] op, input event_req_t e, input bit fix = 1'b0, input logic [15:0] h1 = 16'h0000);
        next_word = '{1'b1, op, fix ? h1 : 16'($urandom), 16'($urandom)};
        ev = e;
        tsel = 2'($urandom);
        repeat (2) @(posedge core_clk);
        #2;
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        logic [15:0] op;
        logic [4:0]  s;
        event_req_t  e;
        logic [10:0] v;
        void'($urandom(32'haf4f97d6));
        repeat (2) @(posedge core_clk);
        #2;
        chk("reset vector", 32'hffff_fff8, vec_out.addr);
        chk("reset decode", 32'h0, {31'h0, dec_out.valid});
        sys_rst = 0;
        // Every selector against every opcode group
        for (int r = 0; r < 160; r++) begin
            s = r[4:0];
            op = {bases[r % 5][7:1], s[4], 4'($urandom), s[3:0]};
            go(op, '0);
            chk("imm_value", exp_imm(op, next_word.half1, next_word.half2), dec_out.imm_value);
            chk("imm_sel", {27'h0, s}, {27'h0, dec_out.imm_sel});
            chk("zero flags", {30'h0, s == 0 && op[15:10] == 6'b011100, s == 0 && op[15:11] == 5'b01101},
                {30'h0, dec_out.any_byte_zero_test, dec_out.carry_conditioned_add});
        end
        $display("immediate test done");
        for (int i = 0; i < 13; i++) begin
            go({8'hce, 8'($urandom)}, '0, 1'b1, EXT_CODES[i]);
            chk("extension", {9'h0, 2'(CLS_EXTEND), 1'b1, 4'(i), EXT_CODES[i]},
                {9'h0, dec_out.cls, dec_out.ext_valid, dec_out.ext_index, dec_out.ext_code});
        end
        for (int i = 0; i < 6; i++) begin
            go({bad[i], 8'($urandom)}, '0, 1'b1, 16'hffff);
            chk("undefined", {30'h0, 2'(CLS_UNDEFINED)}, {30'h0, dec_out.cls});
            op = {4'($urandom % 6), 12'($urandom)};
            go(op, '0);
            chk("row col", {22'h0, 2'(CLS_NORMAL), op[15:8]}, {22'h0, dec_out.cls, dec_out.row, dec_out.col});
        end
        $display("class test done");
        for (int n = 16; n < 64; n++) begin
            for (int k = 0; k < 2; k++) begin
                op = {6'h3f, n[5:4], 4'($urandom), n[3:0]};
                go(op, '0);
                chk("trap_addr", 32'hffff_ff00 + 32'(4 * n), dec_out.trap_addr);
                chk("sw_trap", {31'h0, op != 16'hffff}, {31'h0, dec_out.sw_trap});
            end
        end
        go(16'hffff, '0);
        chk("all ones trap", 32'hffff_fffc, dec_out.trap_addr);
        chk("all ones flag", 32'h1, {31'h0, dec_out.all_ones_trap});
        $display("trap test done");
        for (int i = 0; i < 61; i++) begin
            e = event_req_t'((i < 13 ? 13'h0 : 13'($urandom)) | (13'h1 << (i % 13)));
            go(16'($urandom), e);
            v = exp_vec(e, tsel);
            chk("vector", {21'h0, v}, {21'h0, vec_out.entry, vec_out.priority_level});
            chk("vector addr", {24'hffffff, v[10:5], 2'b00}, vec_out.addr);
            chk("vector valid", 32'h1, {31'h0, vec_out.valid});
        end
        $display("event test done");
        test_done();
    end
endmodule
